// File: core/pocs_map.vh
// Function
// [RL1] answer at 0x20 strap low, 0x28 high
// [RL2] start inrush timer, clamp at power-on
// [RL3] still clamped at window end: fault off
// [RL4] after inrush, supervise cut and hard limit
// [RL5] overload timeout from timing config field
// [RL6] above cut threshold: timer down, zero trips
// [RL7] below threshold: count up slower, saturate
// [RL8] overload trip sets overload fault flag
// [RL9] hard limit imposes foldback at once
// [RL10] hard limit level from high-power bit
// [RL11] hard limit timer; timeout sets fault
// [RL12] cut threshold 3-bit per port field
// [RL13] threshold code to milliamp decode table
// [RL14] host keeps cut below hard limit
// [RL15] autonomous: set limits from class result
// [RL16] cool-down after fault before detection restart
// [RL17] hard timer counts up slower, saturates
// [RL18] fixed down/up rate ratio all ports
// [RL19] fault flags latched until software clears
`ifndef POCS_MAP_VH
`define POCS_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define POCS_OFS_CTRL 4'h0
`define POCS_OFS_CUT 4'h1
`define POCS_OFS_TIMING 4'h2
`define POCS_OFS_POWER_PLUS 4'h3
`define POCS_OFS_FAULT_EVT 4'h4
`define POCS_OFS_START_LIM_EVT 4'h5
`define POCS_OFS_STATUS 4'h6
`define POCS_OFS_I2C_ADDR 4'h7
`define POCS_OFS_CUT_MA 4'h8
// ----------------------------------------
// constants
// ----------------------------------------
`define POCS_ADDR_LOW 7'h20
`define POCS_ADDR_HIGH 7'h28
`define POCS_TIMING_RST 8'h00
`define POCS_CUT_RST 12'h000
`define POCS_UP_RATIO 4'h4
`define POCS_INRUSH_CYC 16'h0400
`define POCS_COOL_CYC 16'h0800
`define POCS_TIMER_UNIT 8'h40
`endif

// File: core/pocs_supervisor.v
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pocs_map.vh"
module pocs_supervisor #(
  parameter PORTS = 4,
  parameter INRUSH_CYC = 16'h0400,
  parameter COOL_CYC = 16'h0800
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // strap
  input wire address_select_pin,
  output reg [6:0] i2c_address,
  // port power requests and current comparators, per port bit
  input wire [3:0] power_on_req,
  input wire [3:0] at_inrush_limit,
  input wire [3:0] above_cut,
  input wire [3:0] above_hard,
  // classification result (power-plus wanted)
  input wire [3:0] class_high_power,
  // port drive
  output reg [3:0] port_power,
  output reg [3:0] foldback_active,
  output reg [3:0] detect_restart,
  output reg [15:0] cut_code_out,
  output reg [3:0] hard_level_high
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_OFF = 2'd0;
  localparam ST_INRUSH = 2'd1;
  localparam ST_ON = 2'd2;
  localparam ST_COOL = 2'd3;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [3:0] auto_reg; // per-port autonomous bits
  reg auto_mode_reg; // global autonomous mode
  reg [11:0] cut_reg; // 3-bit code per port
  reg [7:0] timing_reg; // [3:0] overload, [7:4] hard
  reg [3:0] pplus_reg; // high-power select bits
  reg [3:0] ovl_flag_reg;
  reg [3:0] inr_flag_reg;
  reg [3:0] hard_flag_reg;
  reg [1:0] st_reg [0:3];
  reg [15:0] cnt_reg [0:3]; // inrush and cool count
  reg [11:0] ovl_reg [0:3]; // overload fault timer
  reg [11:0] hard_reg [0:3]; // hard-limit fault timer
  reg [3:0] div_reg [0:3]; // slow up-count divider
  reg strap_done_reg;
  reg [3:0] trip_ovl, trip_inr, trip_hard;
  integer i; // loop index, port supervision only
  integer j; // loop index, limit selection only
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // timeout setting to full-scale count; zero setting still gives one unit
  function [11:0] full_count;
    input [3:0] sel;
    begin
      full_count = {4'h0, `POCS_TIMER_UNIT} * ({8'h00, sel} + 12'h001);
    end
  endfunction
  // threshold code for milliamp in nominal units, readable for status
  // [RL13] code decode table
  function [9:0] cut_ma;
    input [2:0] code;
    begin
      case (code)
        3'h1: cut_ma = 10'd110;
        3'h2: cut_ma = 10'd204;
        3'h4: cut_ma = 10'd754;
        3'h5: cut_ma = 10'd592;
        3'h6: cut_ma = 10'd645;
        3'h7: cut_ma = 10'd920;
        default: cut_ma = 10'd374;
      endcase
    end
  endfunction
  // ----------------------------------------
  // strap catch after reset release
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_done_reg <= 1'b0;
      i2c_address <= `POCS_ADDR_HIGH;
    end else if (!strap_done_reg) begin
      // strap read once; later pin changes are ignored
      strap_done_reg <= 1'b1;
      // [RL1] strap picks address
      i2c_address <= address_select_pin ? `POCS_ADDR_HIGH : `POCS_ADDR_LOW;
    end
  end
  // ----------------------------------------
  // port supervision
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 4; i = i + 1) begin
        st_reg[i] <= ST_OFF;
        cnt_reg[i] <= 16'h0000;
        ovl_reg[i] <= 12'h000;
        hard_reg[i] <= 12'h000;
        div_reg[i] <= 4'h0;
      end
      port_power <= 4'h0;
      foldback_active <= 4'h0;
      detect_restart <= 4'h0;
      trip_ovl <= 4'h0;
      trip_inr <= 4'h0;
      trip_hard <= 4'h0;
    end else begin
      // every port runs its own copy of the same machine
      for (i = 0; i < 4; i = i + 1) begin
        trip_ovl[i] <= 1'b0;
        trip_inr[i] <= 1'b0;
        trip_hard[i] <= 1'b0;
        detect_restart[i] <= 1'b0;
        // [RL9] foldback registered one cycle after hard limit reached
        foldback_active[i] <= port_power[i] & above_hard[i];
        case (st_reg[i])
          ST_OFF: begin
            if (power_on_req[i]) begin
              // [RL2] start inrush window
              st_reg[i] <= ST_INRUSH;
              cnt_reg[i] <= INRUSH_CYC;
              port_power[i] <= 1'b1;
            end
          end
          ST_INRUSH: begin
            if (!power_on_req[i]) begin
              // request dropped during start: plain power-off
              st_reg[i] <= ST_OFF;
              port_power[i] <= 1'b0;
              detect_restart[i] <= 1'b1;
            end else if (cnt_reg[i] != 16'h0000) begin
              cnt_reg[i] <= cnt_reg[i] - 16'h0001;
            end else if (at_inrush_limit[i]) begin
              // [RL3] still clamped at end
              st_reg[i] <= ST_COOL;
              cnt_reg[i] <= COOL_CYC;
              port_power[i] <= 1'b0;
              trip_inr[i] <= 1'b1;
            end else begin
              // [RL4] enter two-tier supervision
              st_reg[i] <= ST_ON;
              ovl_reg[i] <= full_count(timing_reg[3:0]);
              hard_reg[i] <= full_count(timing_reg[7:4]);
              div_reg[i] <= 4'h0;
            end
          end
          ST_ON: begin
            // [RL18] common fixed up-count divider
            div_reg[i] <= (div_reg[i] == `POCS_UP_RATIO - 4'h1) ? 4'h0 : div_reg[i] + 4'h1;
            // [RL6] overload counts down
            if (above_cut[i]) begin
              ovl_reg[i] <= ovl_reg[i] - 12'h001;
            // [RL7] slow up, saturate at setting
            end else if (div_reg[i] == 4'h0 && ovl_reg[i] < full_count(timing_reg[3:0])) begin
              ovl_reg[i] <= ovl_reg[i] + 12'h001;
            end
            // [RL11] hard-limit timer down
            if (above_hard[i]) begin
              hard_reg[i] <= hard_reg[i] - 12'h001;
            // [RL17] slow up, saturate at setting
            end else if (div_reg[i] == 4'h0 && hard_reg[i] < full_count(timing_reg[7:4])) begin
              hard_reg[i] <= hard_reg[i] + 12'h001;
            end
            // trip checks see this cycle's timers; hard before overload
            if (!power_on_req[i]) begin
              // plain power-off: straight back to detection
              st_reg[i] <= ST_OFF;
              port_power[i] <= 1'b0;
              detect_restart[i] <= 1'b1;
            end else if (above_hard[i] && hard_reg[i] <= 12'h001) begin
              // [RL11] hard timeout powers off
              st_reg[i] <= ST_COOL;
              cnt_reg[i] <= COOL_CYC;
              port_power[i] <= 1'b0;
              trip_hard[i] <= 1'b1;
            end else if (above_cut[i] && ovl_reg[i] <= 12'h001) begin
              // [RL6] overload timeout powers off
              st_reg[i] <= ST_COOL;
              cnt_reg[i] <= COOL_CYC;
              port_power[i] <= 1'b0;
              trip_ovl[i] <= 1'b1;
            end
          end
          ST_COOL: begin
            // [RL16] cool-down then detection
            if (cnt_reg[i] != 16'h0000) begin
              cnt_reg[i] <= cnt_reg[i] - 16'h0001;
            end else begin
              st_reg[i] <= ST_OFF;
              detect_restart[i] <= 1'b1;
            end
          end
          default: st_reg[i] <= ST_OFF;
        endcase
      end
    end
  end
  // ----------------------------------------
  // limit selection, autonomous override
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cut_code_out <= 16'h0000;
      hard_level_high <= 4'h0;
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        // limits change only while port is off
        // swapping limits under load could trip on a stale mix
        if (st_reg[j] == ST_OFF) begin
          if (auto_mode_reg | auto_reg[j]) begin
            // [RL15] limits from classification
            cut_code_out[j*4 +: 4] <= class_high_power[j] ? 4'h6 : 4'h0;
            hard_level_high[j] <= class_high_power[j];
          end else begin
            // [RL12] per port 3-bit code
            cut_code_out[j*4 +: 4] <= {1'b0, cut_reg[j*3 +: 3]};
            // [RL10] high-power bit level
            hard_level_high[j] <= pplus_reg[j];
          end
        end
      end
    end
  end
  // ----------------------------------------
  // register writes and flags
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      auto_reg <= 4'h0;
      auto_mode_reg <= 1'b1;
      cut_reg <= `POCS_CUT_RST;
      timing_reg <= `POCS_TIMING_RST;
      pplus_reg <= 4'h0;
      ovl_flag_reg <= 4'h0;
      inr_flag_reg <= 4'h0;
      hard_flag_reg <= 4'h0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `POCS_OFS_CTRL: begin
            auto_reg <= reg_wdata[3:0];
            auto_mode_reg <= reg_wdata[4];
          end
          `POCS_OFS_CUT: cut_reg <= reg_wdata[11:0];
          // [RL5] overload timeout field
          `POCS_OFS_TIMING: timing_reg <= reg_wdata[7:0];
          `POCS_OFS_POWER_PLUS: pplus_reg <= reg_wdata[3:0];
          // writes to read-only or unmapped indexes are dropped
          default: ;
        endcase
      end
      // [RL19] write-one clears, set wins
      // [RL8] overload fault flag
      ovl_flag_reg <= (ovl_flag_reg & ~((reg_wr && reg_addr == `POCS_OFS_FAULT_EVT) ?
                       reg_wdata[3:0] : 4'h0)) | trip_ovl;
      // [RL3] inrush fault flag
      inr_flag_reg <= (inr_flag_reg & ~((reg_wr && reg_addr == `POCS_OFS_START_LIM_EVT) ?
                       reg_wdata[3:0] : 4'h0)) | trip_inr;
      // [RL11] hard-limit fault flag
      hard_flag_reg <= (hard_flag_reg & ~((reg_wr && reg_addr == `POCS_OFS_START_LIM_EVT) ?
                        reg_wdata[7:4] : 4'h0)) | trip_hard;
    end
  end
  // ----------------------------------------
  // read data, one cycle later
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `POCS_OFS_CTRL: reg_rdata <= {11'h000, auto_mode_reg, auto_reg};
        `POCS_OFS_CUT: reg_rdata <= {4'h0, cut_reg};
        `POCS_OFS_TIMING: reg_rdata <= {8'h00, timing_reg};
        `POCS_OFS_POWER_PLUS: reg_rdata <= {12'h000, pplus_reg};
        `POCS_OFS_FAULT_EVT: reg_rdata <= {12'h000, ovl_flag_reg};
        `POCS_OFS_START_LIM_EVT: reg_rdata <= {8'h00, hard_flag_reg, inr_flag_reg};
        // status bits are live copies, not latched
        `POCS_OFS_STATUS: reg_rdata <= {4'h0, foldback_active, 4'h0, port_power};
        `POCS_OFS_I2C_ADDR: reg_rdata <= {9'h000, i2c_address};
        // [RL13] nominal milliamps of the code port 0 uses
        `POCS_OFS_CUT_MA: reg_rdata <= {6'h00, cut_ma(cut_code_out[2:0])};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/pocs_load.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port load model
// ----
module pocs_load (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // per port: 0 good, 1 stuck, 2 overload, 3 short
  input wire logic [7:0] load_mode,
  // gate in, comparators out
  input wire logic [3:0] port_power,
  output logic [3:0] at_inrush_limit,
  output logic [3:0] above_cut,
  output logic [3:0] above_hard
);
  logic [1:0] chg [4]; // charge cycles
  // a good load leaves the clamp after three cycles
  always @(posedge clock or negedge nrst) begin
    for (int i = 0; i < 4; i++) begin
      if (!nrst || !port_power[i]) chg[i] <= 2'h0;
      else if (chg[i] != 2'h3) chg[i] <= chg[i] + 2'h1;
    end
  end
  // no current with the gate off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      at_inrush_limit[i] = port_power[i] && (chg[i] != 2'h3 || load_mode[2*i +: 2] == 2'h1);
      above_cut[i] = port_power[i] && load_mode[2*i +: 2] >= 2'h2;
      above_hard[i] = port_power[i] && load_mode[2*i +: 2] == 2'h3;
    end
  end
endmodule
`default_nettype wire

// File: tb/pocs_sva_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module pocs_sva #(
  parameter int INRUSH_CYC = 16,
  parameter int COOL_CYC = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // strap
  input wire logic address_select_pin,
  input wire logic [6:0] i2c_address,
  // port side
  input wire logic [3:0] power_on_req,
  input wire logic [3:0] above_hard,
  input wire logic [3:0] port_power,
  input wire logic [3:0] foldback_active,
  input wire logic [3:0] detect_restart
);
  // slack: the flag lands a cycle after the trip
  localparam int COOL_LO = COOL_CYC - 2;
  localparam int COOL_HI = COOL_CYC + 4;
  logic [15:0] on_cnt; // cycles port 0 has been on
  // on-time of port 0
  always @(posedge clock or negedge nrst) begin
    if (!nrst) on_cnt <= 16'h0000;
    else on_cnt <= port_power[0] ? on_cnt + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // dropped while still requested: a trip
  sequence s_fault_off;
    $fell(port_power[0]) ##0 power_on_req[0];
  endsequence
  a_addr_strap: assert property ($past(nrst, 2) |->
    i2c_address == (address_select_pin ? 7'h28 : 7'h20)) else $error("bad address");
  a_fold_follow: assert property (foldback_active == $past(port_power & above_hard))
    else $error("bad foldback");
  a_req_gate: assert property ((port_power & ~$past(power_on_req)) == 4'h0)
    else $error("power without request");
  a_inrush_hold: assert property (s_fault_off |-> on_cnt + 16'h0002 >= INRUSH_CYC)
    else $error("trip inside inrush window");
  a_off_cool: assert property (s_fault_off |=> !port_power[0] [*8])
    else $error("power during cool-down");
  a_restart_bound: assert property (s_fault_off |-> ##[COOL_LO:COOL_HI] detect_restart[0])
    else $error("restart late");
  a_restart_pulse: assert property (detect_restart[0] |=> !detect_restart[0])
    else $error("restart not a pulse");
  a_rd_unmapped: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
    else $error("unmapped read");
endmodule
bind pocs_supervisor pocs_sva #(.INRUSH_CYC(INRUSH_CYC), .COOL_CYC(COOL_CYC)) pocs_sva_i (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .address_select_pin(address_select_pin), .i2c_address(i2c_address), .power_on_req(power_on_req),
  .above_hard(above_hard), .port_power(port_power), .foldback_active(foldback_active),
  .detect_restart(detect_restart));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// supervisor bench
// ----
module testbench;
  localparam int INRUSH = 16; // short window
  // nominal cut milliamps, code 7 at the top
  localparam logic [79:0] MA_TAB = {10'd920, 10'd645, 10'd592, 10'd754, 10'd374, 10'd204, 10'd110, 10'd374};
  logic clock, nrst, reg_wr, reg_rd, address_select_pin;
  logic [3:0] reg_addr, power_on_req, class_high_power, port_power, foldback_active, detect_restart;
  logic [3:0] at_inrush_limit, above_cut, above_hard, hard_level_high;
  logic [15:0] reg_wdata, reg_rdata, cut_code_out;
  logic [6:0] i2c_address;
  logic [7:0] load_mode;
  int err_count, checked, cycles, n;
  pocs_supervisor #(.PORTS(4), .INRUSH_CYC(16'h0010), .COOL_CYC(16'h0020)) pocs_supervisor_i (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .address_select_pin(address_select_pin),
    .i2c_address(i2c_address), .power_on_req(power_on_req), .at_inrush_limit(at_inrush_limit),
    .above_cut(above_cut), .above_hard(above_hard), .class_high_power(class_high_power),
    .port_power(port_power), .foldback_active(foldback_active), .detect_restart(detect_restart),
    .cut_code_out(cut_code_out), .hard_level_high(hard_level_high));
  pocs_load pocs_load_i (.clock(clock), .nrst(nrst), .load_mode(load_mode), .port_power(port_power),
    .at_inrush_limit(at_inrush_limit), .above_cut(above_cut), .above_hard(above_hard));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude;
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
  endtask
  // strobes drop for a cycle so back-to-back calls never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step(1);
    reg_wr <= 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    step(1);
    reg_rd <= 1'b0;
    step(1);
    chk(reg_rdata, e);
  endtask
  // cycles until port 0 drops
  task automatic run_on(input int lim);
    n = 0;
    while (port_power[0] !== 1'b0 && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic wait_restart;
    int k;
    k = 0;
    while (detect_restart[0] !== 1'b1 && k < 80) begin
      step(1);
      k++;
    end
    chk({15'h0000, detect_restart[0]}, 16'h0001);
  endtask
  task automatic idle;
    power_on_req <= 4'h0;
    load_mode <= 8'h00;
    step(4);
  endtask
  task automatic go(input logic s);
    nrst <= 1'b0;
    address_select_pin <= s;
    step(3);
    nrst <= 1'b1;
    step(3);
    chk({9'h000, i2c_address}, s ? 16'h0028 : 16'h0020);
    rd(4'h7, s ? 16'h0028 : 16'h0020);
  endtask
  task automatic t_auto;
    rd(4'h0, 16'h0010);
    class_high_power <= 4'h1;
    power_on_req <= 4'h1;
    step(4);
    chk(cut_code_out, 16'h0006);
    chk({12'h000, hard_level_high}, 16'h0001);
    step(INRUSH + 8);
    chk({12'h000, port_power}, 16'h0001);
    class_high_power <= 4'h3;
    idle();
    // per-port autonomous bit alone, global mode off
    wr(4'h0, 16'h0001);
    step(1);
    chk(cut_code_out, 16'h0006);
    class_high_power <= 4'h0;
  endtask
  task automatic t_regs;
    logic [2:0] c;
    wr(4'h0, 16'h0000);
    rd(4'hf, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(4'h1, {4'h0, c, c, c, c});
      rd(4'h1, {4'h0, c, c, c, c});
      chk(cut_code_out, {1'b0, c, 1'b0, c, 1'b0, c, 1'b0, c});
      rd(4'h8, {6'h00, MA_TAB[i*10 +: 10]});
    end
    // host keeps cut code 0 under either hard limit
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0009);
    wr(4'h2, 16'h0001);
    chk({12'h000, hard_level_high}, 16'h0009);
  endtask
  task automatic t_inrush;
    load_mode <= 8'h01;
    power_on_req <= 4'h1;
    step(2);
    run_on(40);
    chk({15'h0000, n >= INRUSH - 2 && n <= INRUSH + 2}, 16'h0001);
    rd(4'h5, 16'h0001);
    wait_restart();
    rd(4'h5, 16'h0001);
    wr(4'h5, 16'h0001);
    rd(4'h5, 16'h0000);
    idle();
  endtask
  task automatic t_overload;
    power_on_req <= 4'h1;
    step(INRUSH + 6);
    load_mode <= 8'h02;
    step(40);
    load_mode <= 8'h00;
    step(40);
    load_mode <= 8'h02;
    step(90);
    chk({12'h000, port_power}, 16'h0001);
    run_on(20);
    chk({15'h0000, n >= 3 && n <= 12}, 16'h0001);
    rd(4'h4, 16'h0001);
    wait_restart();
    wr(4'h4, 16'h0001);
    idle();
  endtask
  task automatic t_hard;
    power_on_req <= 4'h1;
    step(INRUSH + 6);
    load_mode <= 8'h03;
    step(3);
    chk({12'h000, foldback_active}, 16'h0001);
    rd(4'h6, 16'h0101);
    step(53);
    chk({12'h000, port_power}, 16'h0001);
    run_on(20);
    chk({15'h0000, n >= 2 && n <= 10}, 16'h0001);
    rd(4'h5, 16'h0010);
    rd(4'h4, 16'h0000);
    wait_restart();
    wr(4'h5, 16'h0010);
    idle();
  endtask
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    power_on_req = 4'h0;
    class_high_power = 4'h0;
    load_mode = 8'h00;
    go(1'b0);
    t_auto();
    t_regs();
    t_inrush();
    t_overload();
    t_hard();
    go(1'b1);
    conclude();
  end
endmodule
`default_nettype wire
